/* pkg/ccs_pkg.sv */
package ccs_pkg;
   localparam int WORD_W = 32;
   localparam int SR_W = 16;
   localparam int SPACE_W = 3;
   localparam int SR_C = 0;
   localparam int SR_V = 1;
   localparam int SR_Z = 2;
   localparam int SR_N = 3;
   localparam int SR_X = 4;
   localparam int SR_IPM_LO = 8;
   localparam int SR_IPM_HI = 10;
   localparam int SR_M = 12;
   localparam int SR_S = 13;
   localparam int SR_T0 = 14;
   localparam int SR_T1 = 15;
   localparam int CCR_HI = 7;
   localparam logic [15:0] SR_RESET = 16'h2700;
   localparam logic [15:0] SR_IMPL_MASK = 16'hF71F;
   localparam logic [2:0] FC_USER_DATA = 3'h1;
   localparam logic [2:0] FC_USER_PROG = 3'h2;
   localparam logic [2:0] FC_SUP_DATA = 3'h5;
   localparam logic [2:0] FC_SUP_PROG = 3'h6;
   localparam logic [2:0] FC_RESET = 3'h0;
   localparam logic [31:0] WORD_RESET = 32'h0;
   localparam int ICACHE_CONTROL_REG_EN = 0;
   localparam int ICACHE_CONTROL_REG_FRZ = 1;
   localparam int ICACHE_CONTROL_REG_CLR_ENT = 2;
   localparam int ICACHE_CONTROL_REG_CLR_ALL = 3;
   localparam int VEC_SHIFT = 2;
   localparam int NREG = 16;
   localparam logic [3:0] SP_INDEX = 4'hF;
   localparam logic [4:0] BF_FULL = 5'h0;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_QUAD} ccs_size_t;
endpackage

/* rtl/ccs_gpr_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module ccs_gpr_bank (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic sup_i,
   input wire logic master_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_sel_i,
   input wire ccs_pkg::ccs_size_t wr_size_i,
   input wire logic [31:0] wr_data_i,
   input wire logic [2:0] wr_pair_sel_i,
   input wire logic [31:0] wr_data_hi_i,
   input wire logic [3:0] rd_a_sel_i,
   input wire logic [3:0] rd_b_sel_i,
   output logic [31:0] rd_a_o,
   output logic [31:0] rd_b_o
);
   logic [31:0] file_r [0:ccs_pkg::NREG-2];
   logic [31:0] usp_r, isp_r, msp_r;
   wire [31:0] active_sp;
   wire sp_wr;

   // addresses take word writes sign-extended; byte forms have no address meaning
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input ccs_pkg::ccs_size_t sz, input logic is_addr);
      logic [31:0] r;
      r = nw;
      if (sz == ccs_pkg::SZ_WORD) begin
         r = is_addr ? {{16{nw[15]}}, nw[15:0]} : {old[31:16], nw[15:0]};
      end else if (sz == ccs_pkg::SZ_BYTE && !is_addr) begin
         r = {old[31:8], nw[7:0]};
      end
      return r;
   endfunction

   function automatic logic [31:0] rd(input logic [3:0] sel, input logic [31:0] sp);
      return (sel == ccs_pkg::SP_INDEX) ? sp : file_r[sel];
   endfunction

   assign active_sp = !sup_i ? usp_r : (master_i ? msp_r : isp_r);
   assign sp_wr = wr_en_i && wr_sel_i == ccs_pkg::SP_INDEX;

   genvar g;
   generate
      for (g = 0; g < ccs_pkg::NREG - 1; g++) begin : g_reg
         localparam logic is_addr = (g >= 8);
         wire sel_hit = wr_en_i && wr_sel_i == 4'(g);
         wire hi_hit = wr_en_i && !is_addr && wr_size_i == ccs_pkg::SZ_QUAD &&
                       wr_pair_sel_i == 3'(g) && !wr_sel_i[3];
         always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               file_r[g] <= ccs_pkg::WORD_RESET;
            end else if (hi_hit) begin
               file_r[g] <= wr_data_hi_i;
            end else if (sel_hit) begin
               file_r[g] <= merge(file_r[g], wr_data_i, wr_size_i, is_addr);
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         usp_r <= ccs_pkg::WORD_RESET;
         isp_r <= ccs_pkg::WORD_RESET;
         msp_r <= ccs_pkg::WORD_RESET;
      end else if (sp_wr) begin
         if (!sup_i) usp_r <= merge(usp_r, wr_data_i, wr_size_i, 1'b1);
         else if (master_i) msp_r <= merge(msp_r, wr_data_i, wr_size_i, 1'b1);
         else isp_r <= merge(isp_r, wr_data_i, wr_size_i, 1'b1);
      end
   end

   assign rd_a_o = rd(rd_a_sel_i, active_sp);
   assign rd_b_o = rd(rd_b_sel_i, active_sp);
endmodule
`default_nettype wire

/* rtl/ccs_space_code.sv */
`timescale 1ns/1ns
`default_nettype none
module ccs_space_code (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic sup_i,
   input wire logic sfc_wr_en_i,
   input wire logic dfc_wr_en_i,
   input wire logic [2:0] code_data_i,
   input wire logic bus_cycle_i,
   input wire logic bus_prog_i,
   input wire logic alt_src_i,
   input wire logic alt_dst_i,
   output logic [2:0] address_space_code_pins_o,
   output logic space_valid_o,
   output logic alt_refused_o,
   output logic [2:0] source_space_code_reg_o,
   output logic [2:0] dest_space_code_reg_o
);
   logic [2:0] sfc_r, dfc_r, fc_r;
   logic valid_r, refused_r;
   wire [2:0] plain_code, fc_nxt;
   wire alt_ok;

   assign plain_code = sup_i ? (bus_prog_i ? ccs_pkg::FC_SUP_PROG : ccs_pkg::FC_SUP_DATA)
                             : (bus_prog_i ? ccs_pkg::FC_USER_PROG : ccs_pkg::FC_USER_DATA);
   // alternate space only honoured from supervisor state
   assign alt_ok = sup_i && (alt_src_i || alt_dst_i);
   assign fc_nxt = !alt_ok ? plain_code : (alt_src_i ? sfc_r : dfc_r);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sfc_r <= ccs_pkg::FC_RESET;
         dfc_r <= ccs_pkg::FC_RESET;
         fc_r <= ccs_pkg::FC_RESET;
         valid_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         if (sfc_wr_en_i && sup_i) sfc_r <= code_data_i;
         if (dfc_wr_en_i && sup_i) dfc_r <= code_data_i;
         if (bus_cycle_i) fc_r <= fc_nxt;
         valid_r <= bus_cycle_i;
         refused_r <= bus_cycle_i && !sup_i && (alt_src_i || alt_dst_i);
      end
   end

   assign address_space_code_pins_o = fc_r;
   assign space_valid_o = valid_r;
   assign alt_refused_o = refused_r;
   assign source_space_code_reg_o = sfc_r;
   assign dest_space_code_reg_o = dfc_r;
endmodule
`default_nettype wire

/* rtl/ccs_regs_top.sv */
`timescale 1ns/1ns
`default_nettype none
module ccs_regs_top (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // general register file
   input wire logic gpr_wr_en_i,
   input wire logic [3:0] gpr_wr_sel_i,
   input wire ccs_pkg::ccs_size_t gpr_wr_size_i,
   input wire logic [31:0] gpr_wr_data_i,
   input wire logic [2:0] gpr_pair_sel_i,
   input wire logic [31:0] gpr_wr_data_hi_i,
   input wire logic [3:0] gpr_rd_sel_i,
   output logic [31:0] gpr_rd_data_o,
   // index and bit-field operand paths
   input wire logic [3:0] idx_sel_i,
   input wire logic idx_long_i,
   input wire logic [1:0] idx_scale_i,
   output logic [31:0] idx_value_o,
   input wire logic [4:0] bf_offset_i,
   input wire logic [4:0] bf_width_i,
   output logic [31:0] bf_field_o,
   output logic bit_value_o,
   // status register
   input wire logic sr_wr_en_i,
   input wire logic [15:0] sr_wr_data_i,
   input wire logic ccr_wr_en_i,
   input wire logic [4:0] ccr_wr_data_i,
   output logic [15:0] sr_o,
   output logic priv_err_o,
   // trace
   input wire logic instr_done_i,
   input wire logic instr_flow_i,
   output logic trace_trap_o,
   // program counter and vector base
   input wire logic pc_wr_en_i,
   input wire logic [31:0] pc_wr_data_i,
   output logic [31:0] pc_o,
   input wire logic vbr_wr_en_i,
   input wire logic [31:0] vbr_wr_data_i,
   input wire logic [7:0] vector_num_i,
   output logic [31:0] vbr_o,
   output logic [31:0] vector_addr_o,
   // alternate space registers and bus cycle
   input wire logic sfc_wr_en_i,
   input wire logic dfc_wr_en_i,
   input wire logic [2:0] space_wr_data_i,
   input wire logic bus_cycle_i,
   input wire logic bus_prog_i,
   input wire logic alt_src_i,
   input wire logic alt_dst_i,
   output logic [2:0] address_space_code_pins_o,
   output logic space_valid_o,
   output logic alt_refused_o,
   output logic [2:0] source_space_code_reg_o,
   output logic [2:0] dest_space_code_reg_o,
   // instruction cache control
   input wire logic icache_control_reg_wr_en_i,
   input wire logic [31:0] icache_control_reg_wr_data_i,
   input wire logic icache_addr_reg_wr_en_i,
   input wire logic [31:0] icache_addr_reg_wr_data_i,
   output logic [31:0] icache_control_reg_o,
   output logic [31:0] icache_addr_reg_o,
   output logic icache_enable_o,
   output logic icache_freeze_o,
   output logic icache_clr_entry_o,
   output logic icache_clr_all_o
);
   logic [15:0] sr_r, sr_nxt;
   logic [31:0] pc_r, vbr_r, icache_addr_reg_r, vec_r, rd_r, idx_r, bf_r;
   logic en_r, frz_r, clr_ent_r, clr_all_r, trap_r, perr_r, bit_r;
   wire [31:0] rd_a, rd_b, idx_raw, bf_shift, bf_mask;
   wire sup, master, trace_all_bit, trace_flow_bit, trap_nxt, priv_wr;

   assign sup = sr_r[ccs_pkg::SR_S];
   assign master = sr_r[ccs_pkg::SR_M];
   assign trace_all_bit = sr_r[ccs_pkg::SR_T0];
   assign trace_flow_bit = sr_r[ccs_pkg::SR_T1];

   ccs_gpr_bank u_bank (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .sup_i(sup),
      .master_i(master),
      .wr_en_i(gpr_wr_en_i),
      .wr_sel_i(gpr_wr_sel_i),
      .wr_size_i(gpr_wr_size_i),
      .wr_data_i(gpr_wr_data_i),
      .wr_pair_sel_i(gpr_pair_sel_i),
      .wr_data_hi_i(gpr_wr_data_hi_i),
      .rd_a_sel_i(gpr_rd_sel_i),
      .rd_b_sel_i(idx_sel_i),
      .rd_a_o(rd_a),
      .rd_b_o(rd_b)
   );

   ccs_space_code u_space (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .sup_i(sup),
      .sfc_wr_en_i(sfc_wr_en_i),
      .dfc_wr_en_i(dfc_wr_en_i),
      .code_data_i(space_wr_data_i),
      .bus_cycle_i(bus_cycle_i),
      .bus_prog_i(bus_prog_i),
      .alt_src_i(alt_src_i),
      .alt_dst_i(alt_dst_i),
      .address_space_code_pins_o(address_space_code_pins_o),
      .space_valid_o(space_valid_o),
      .alt_refused_o(alt_refused_o),
      .source_space_code_reg_o(source_space_code_reg_o),
      .dest_space_code_reg_o(dest_space_code_reg_o)
   );

   // index: word form is sign-extended before scaling
   assign idx_raw = idx_long_i ? rd_b : {{16{rd_b[15]}}, rd_b[15:0]};
   // bit-field from the read-port register, width zero means 32
   assign bf_shift = rd_a >> bf_offset_i;
   assign bf_mask = (bf_width_i == ccs_pkg::BF_FULL) ? ~32'h0 : ~(~32'h0 << bf_width_i);

   // user state may only touch the condition code byte
   assign priv_wr = (sr_wr_en_i || vbr_wr_en_i || icache_control_reg_wr_en_i || icache_addr_reg_wr_en_i ||
                     sfc_wr_en_i || dfc_wr_en_i) && !sup;

   always_comb begin
      sr_nxt = sr_r;
      if (sr_wr_en_i && sup) begin
         sr_nxt = sr_wr_data_i & ccs_pkg::SR_IMPL_MASK;
      end else if (sr_wr_en_i) begin
         sr_nxt[ccs_pkg::CCR_HI:0] = sr_wr_data_i[ccs_pkg::CCR_HI:0] &
                                     ccs_pkg::SR_IMPL_MASK[ccs_pkg::CCR_HI:0];
      end else if (ccr_wr_en_i) begin
         sr_nxt[ccs_pkg::SR_X:ccs_pkg::SR_C] = ccr_wr_data_i;
      end
   end

   // T0 traps every instruction, T1 only change-of-flow ones
   assign trap_nxt = instr_done_i && (trace_all_bit || (trace_flow_bit && instr_flow_i));

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sr_r <= ccs_pkg::SR_RESET;
         trap_r <= 1'b0;
         perr_r <= 1'b0;
      end else begin
         sr_r <= sr_nxt;
         trap_r <= trap_nxt;
         perr_r <= priv_wr;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pc_r <= ccs_pkg::WORD_RESET;
         vbr_r <= ccs_pkg::WORD_RESET;
         vec_r <= ccs_pkg::WORD_RESET;
      end else begin
         if (pc_wr_en_i) pc_r <= pc_wr_data_i;
         if (vbr_wr_en_i && sup) vbr_r <= vbr_wr_data_i;
         vec_r <= vbr_r + (32'(vector_num_i) << ccs_pkg::VEC_SHIFT);
      end
   end

   // clear requests are one-shot pulses and never stored
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         en_r <= 1'b0;
         frz_r <= 1'b0;
         clr_ent_r <= 1'b0;
         clr_all_r <= 1'b0;
         icache_addr_reg_r <= ccs_pkg::WORD_RESET;
      end else begin
         if (icache_control_reg_wr_en_i && sup) begin
            en_r <= icache_control_reg_wr_data_i[ccs_pkg::ICACHE_CONTROL_REG_EN];
            frz_r <= icache_control_reg_wr_data_i[ccs_pkg::ICACHE_CONTROL_REG_FRZ];
         end
         clr_ent_r <= icache_control_reg_wr_en_i && sup && icache_control_reg_wr_data_i[ccs_pkg::ICACHE_CONTROL_REG_CLR_ENT];
         clr_all_r <= icache_control_reg_wr_en_i && sup && icache_control_reg_wr_data_i[ccs_pkg::ICACHE_CONTROL_REG_CLR_ALL];
         if (icache_addr_reg_wr_en_i && sup) icache_addr_reg_r <= icache_addr_reg_wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_r <= ccs_pkg::WORD_RESET;
         idx_r <= ccs_pkg::WORD_RESET;
         bf_r <= ccs_pkg::WORD_RESET;
         bit_r <= 1'b0;
      end else begin
         rd_r <= rd_a;
         idx_r <= idx_raw << idx_scale_i;
         bf_r <= bf_shift & bf_mask;
         bit_r <= bf_shift[0];
      end
   end

   assign gpr_rd_data_o = rd_r;
   assign idx_value_o = idx_r;
   assign bf_field_o = bf_r;
   assign bit_value_o = bit_r;
   assign sr_o = sr_r;
   assign priv_err_o = perr_r;
   assign trace_trap_o = trap_r;
   assign pc_o = pc_r;
   assign vbr_o = vbr_r;
   assign vector_addr_o = vec_r;
   assign icache_control_reg_o = {30'h0, frz_r, en_r};
   assign icache_addr_reg_o = icache_addr_reg_r;
   assign icache_enable_o = en_r;
   assign icache_freeze_o = frz_r;
   assign icache_clr_entry_o = clr_ent_r;
   assign icache_clr_all_o = clr_all_r;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   trace_all_trap_a: assert property (instr_done_i && trace_all_bit |=> trace_trap_o)
      else $error("trace-all did not trap");
   trace_flow_only_a: assert property (instr_done_i && trace_flow_bit && !trace_all_bit
      |=> trace_trap_o == $past(instr_flow_i))
      else $error("flow trace trapped wrongly");
   ccr_update_a: assert property (ccr_wr_en_i && !sr_wr_en_i
      |=> sr_o[4:0] == $past(ccr_wr_data_i) && sr_o[15:8] == $past(sr_o[15:8]))
      else $error("condition codes not updated");
   user_priv_a: assert property (sr_wr_en_i && !sup |=> sr_o[15:8] == $past(sr_o[15:8])
      ##0 priv_err_o)
      else $error("user state changed system byte");
   vector_base_a: assert property (!vbr_wr_en_i ##1 !vbr_wr_en_i
      |=> vector_addr_o == $past(vbr_o, 2) + {22'h0, $past(vector_num_i), 2'b00})
      else $error("vector address wrong");
   space_code_a: assert property (bus_cycle_i && !alt_src_i && !alt_dst_i
      |=> space_valid_o && address_space_code_pins_o[2] == $past(sup)
          && address_space_code_pins_o[1] == $past(bus_prog_i))
      else $error("space code mismatch");
   alt_source_a: assert property (bus_cycle_i && sup && alt_src_i
      |=> address_space_code_pins_o == $past(source_space_code_reg_o))
      else $error("alternate source space not used");
   cache_clear_a: assert property (icache_control_reg_wr_en_i && sup && icache_control_reg_wr_data_i[3]
      |=> icache_clr_all_o ##1 !icache_clr_all_o || $past(icache_control_reg_wr_en_i))
      else $error("cache clear not a pulse");
   index_word_a: assert property (!idx_long_i && idx_scale_i == 2'h0
      |=> idx_value_o[31:16] == {16{idx_value_o[15]}})
      else $error("word index not sign-extended");
   stack_select_a: assert property (gpr_rd_sel_i == 4'hF && sup && master && gpr_wr_en_i
      && gpr_wr_sel_i == 4'hF && gpr_wr_size_i == ccs_pkg::SZ_LONG && !sr_wr_en_i
      && !ccr_wr_en_i |=> gpr_rd_sel_i != 4'hF || rd_a == $past(gpr_wr_data_i))
      else $error("master stack pointer write lost");

   flow_trap_c: cover property (instr_done_i && trace_flow_bit && instr_flow_i ##1 trace_trap_o);
   alt_dest_c: cover property (bus_cycle_i && sup && alt_dst_i);
   quad_write_c: cover property (gpr_wr_en_i && gpr_wr_size_i == ccs_pkg::SZ_QUAD);
   user_bus_c: cover property (!sup && bus_cycle_i ##1 space_valid_o);
endmodule
`default_nettype wire

/* verification/ccs_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ccs_mem_model (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [2:0] address_space_code_pins_i,
   input wire logic space_valid_i,
   output logic super_o,
   output logic prog_o,
   output logic bad_code_o,
   output int acc_count_o
);
   // the code means nothing between cycles, so decode only while flagged
   assign super_o = space_valid_i & address_space_code_pins_i[2];
   assign prog_o = space_valid_i & address_space_code_pins_i[1];
   // 0, 3, 4 and 7 name neither a program nor a data area
   assign bad_code_o = space_valid_i & (address_space_code_pins_i[1] == address_space_code_pins_i[0]);
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_count_o <= 0;
      end else if (space_valid_i) begin
         acc_count_o <= acc_count_o + 1;
      end
   end
endmodule
`default_nettype wire

/* verification/tb_cpu_control_state_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_control_state_regs;
   logic sys_clk_i, rst_b_i, gpr_wr_en_i, idx_long_i, sr_wr_en_i, ccr_wr_en_i, instr_done_i;
   logic instr_flow_i, pc_wr_en_i, vbr_wr_en_i, sfc_wr_en_i, dfc_wr_en_i, bus_cycle_i;
   logic bus_prog_i, alt_src_i, alt_dst_i, icache_control_reg_wr_en_i, icache_addr_reg_wr_en_i;
   logic [3:0] gpr_wr_sel_i, gpr_rd_sel_i, idx_sel_i;
   ccs_pkg::ccs_size_t gpr_wr_size_i;
   logic [31:0] gpr_wr_data_i, gpr_wr_data_hi_i, pc_wr_data_i, vbr_wr_data_i;
   logic [31:0] icache_control_reg_wr_data_i, icache_addr_reg_wr_data_i, r;
   logic [2:0] gpr_pair_sel_i, space_wr_data_i, m_sfc, m_dfc;
   logic [1:0] idx_scale_i;
   logic [4:0] bf_offset_i, bf_width_i, ccr_wr_data_i;
   logic [15:0] sr_wr_data_i, sr_o, m_sr;
   logic [7:0] vector_num_i;
   logic [31:0] gpr_rd_data_o, idx_value_o, bf_field_o, pc_o, vbr_o, vector_addr_o;
   logic [31:0] icache_control_reg_o, icache_addr_reg_o;
   logic bit_value_o, priv_err_o, trace_trap_o, space_valid_o, alt_refused_o;
   logic icache_enable_o, icache_freeze_o, icache_clr_entry_o, icache_clr_all_o;
   logic [2:0] address_space_code_pins_o, source_space_code_reg_o, dest_space_code_reg_o;
   logic m_super, m_prog, m_bad;
   logic [31:0] m_gpr[16];
   logic [31:0] m_sp[3];
   int m_count, fails, check_count, n_bus;

   ccs_regs_top ccs_regs_top_inst (.sys_clk_i, .rst_b_i, .gpr_wr_en_i, .gpr_wr_sel_i,
      .gpr_wr_size_i, .gpr_wr_data_i, .gpr_pair_sel_i, .gpr_wr_data_hi_i, .gpr_rd_sel_i,
      .gpr_rd_data_o, .idx_sel_i, .idx_long_i, .idx_scale_i, .idx_value_o, .bf_offset_i,
      .bf_width_i, .bf_field_o, .bit_value_o, .sr_wr_en_i, .sr_wr_data_i, .ccr_wr_en_i,
      .ccr_wr_data_i, .sr_o, .priv_err_o, .instr_done_i, .instr_flow_i, .trace_trap_o,
      .pc_wr_en_i, .pc_wr_data_i, .pc_o, .vbr_wr_en_i, .vbr_wr_data_i, .vector_num_i, .vbr_o,
      .vector_addr_o, .sfc_wr_en_i, .dfc_wr_en_i, .space_wr_data_i, .bus_cycle_i, .bus_prog_i,
      .alt_src_i, .alt_dst_i, .address_space_code_pins_o, .space_valid_o, .alt_refused_o,
      .source_space_code_reg_o, .dest_space_code_reg_o, .icache_control_reg_wr_en_i, .icache_control_reg_wr_data_i,
      .icache_addr_reg_wr_en_i, .icache_addr_reg_wr_data_i, .icache_control_reg_o, .icache_addr_reg_o,
      .icache_enable_o, .icache_freeze_o, .icache_clr_entry_o, .icache_clr_all_o);
   ccs_mem_model ccs_mem_model_inst (.sys_clk_i, .rst_b_i,
      .address_space_code_pins_i(address_space_code_pins_o), .space_valid_i(space_valid_o),
      .super_o(m_super), .prog_o(m_prog), .bad_code_o(m_bad), .acc_count_o(m_count));

   initial begin
      sys_clk_i = 1'b0;
      forever #20 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_val({31'h0, got}, {31'h0, exp});
   endtask
   task automatic give_verdict;
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic tick;
      @(negedge sys_clk_i);
   endtask
   // strobes are raised by tasks and by the main sequence; idle drops them all and lets an edge pass
   task automatic idle;
      {gpr_wr_en_i, sr_wr_en_i, ccr_wr_en_i, instr_done_i, pc_wr_en_i, vbr_wr_en_i} = '0;
      {sfc_wr_en_i, dfc_wr_en_i, bus_cycle_i, icache_control_reg_wr_en_i, icache_addr_reg_wr_en_i} = '0;
      tick();
   endtask
   function automatic int sp_i();
      return m_sr[ccs_pkg::SR_S] ? (m_sr[ccs_pkg::SR_M] ? 2 : 1) : 0;
   endfunction
   function automatic logic [31:0] m_rd(input logic [3:0] s);
      return (s == 4'hF) ? m_sp[sp_i()] : m_gpr[s];
   endfunction
   task automatic gpr_wr(input logic [3:0] s, input ccs_pkg::ccs_size_t z, input logic [31:0] d,
                         input logic [31:0] h);
      logic [31:0] n, o;
      n = d;
      o = m_rd(s);
      if (s < 8 && z == ccs_pkg::SZ_BYTE) n = {o[31:8], d[7:0]};
      if (s < 8 && z == ccs_pkg::SZ_WORD) n = {o[31:16], d[15:0]};
      if (s >= 8 && z == ccs_pkg::SZ_WORD) n = {{16{d[15]}}, d[15:0]};
      if (s == 4'hF) m_sp[sp_i()] = n; else m_gpr[s] = n;
      if (s < 8 && z == ccs_pkg::SZ_QUAD) m_gpr[5] = h;
      {gpr_wr_sel_i, gpr_wr_data_i, gpr_pair_sel_i, gpr_wr_data_hi_i} = {s, d, 3'h5, h};
      gpr_wr_size_i = z;
      gpr_wr_en_i = 1'b1;
      tick();
   endtask
   task automatic rd_chk(input logic [3:0] s, input logic l, input logic [1:0] k);
      logic [31:0] v;
      v = m_rd(s);
      {gpr_rd_sel_i, idx_sel_i, idx_long_i, idx_scale_i} = {s, s, l, k};
      tick();
      chk_val(gpr_rd_data_o, v);
      chk_val(bf_field_o, v);
      chk_val(idx_value_o, (l ? v : {{16{v[15]}}, v[15:0]}) << k);
   endtask
   task automatic sr_wr(input logic [15:0] d);
      if (m_sr[ccs_pkg::SR_S]) m_sr = d & ccs_pkg::SR_IMPL_MASK;
      else m_sr[7:0] = d[7:0] & ccs_pkg::SR_IMPL_MASK[7:0];
      {sr_wr_en_i, sr_wr_data_i} = {1'b1, d};
      tick();
      chk_val(sr_o, m_sr);
   endtask
   task automatic trace(input logic f, input logic e);
      {instr_done_i, instr_flow_i} = {1'b1, f};
      tick();
      chk_flag(trace_trap_o, e);
   endtask
   task automatic bus(input logic p, input logic s, input logic d);
      logic [2:0] e;
      logic sup;
      sup = m_sr[ccs_pkg::SR_S];
      e = {sup, p, !p};
      if (sup && d) e = m_dfc;
      if (sup && s) e = m_sfc;
      {bus_cycle_i, bus_prog_i, alt_src_i, alt_dst_i} = {1'b1, p, s, d};
      tick();
      n_bus++;
      chk_val(address_space_code_pins_o, e);
      chk_flag(space_valid_o, 1'b1);
      chk_flag(alt_refused_o, (s | d) & !sup);
      chk_val({m_bad, m_super, m_prog}, {1'b0, e[2], e[1]});
   endtask

   initial begin
      {gpr_wr_en_i, gpr_wr_sel_i, gpr_wr_data_i, gpr_pair_sel_i, gpr_wr_data_hi_i} = '0;
      {gpr_rd_sel_i, idx_sel_i, idx_long_i, idx_scale_i, bf_offset_i, bf_width_i} = '0;
      {sr_wr_en_i, sr_wr_data_i, ccr_wr_en_i, ccr_wr_data_i, instr_done_i, instr_flow_i} = '0;
      {pc_wr_en_i, pc_wr_data_i, vbr_wr_en_i, vbr_wr_data_i, vector_num_i, sfc_wr_en_i} = '0;
      {dfc_wr_en_i, space_wr_data_i, bus_cycle_i, bus_prog_i, alt_src_i, alt_dst_i} = '0;
      {icache_control_reg_wr_en_i, icache_control_reg_wr_data_i, icache_addr_reg_wr_en_i, icache_addr_reg_wr_data_i, rst_b_i} = '0;
      gpr_wr_size_i = ccs_pkg::SZ_LONG;
      {fails, check_count, n_bus} = '0;
      m_sr = ccs_pkg::SR_RESET;
      {m_sfc, m_dfc} = '0;
      m_gpr = '{default: 32'h0};
      m_sp = '{default: 32'h0};
      void'($urandom(32'h2308));
      repeat (12) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      chk_val(sr_o, ccs_pkg::SR_RESET);
      chk_val(address_space_code_pins_o, ccs_pkg::FC_RESET);
      sr_wr(16'hA71F);
      repeat (8) begin
         r = $urandom;
         sr_wr((r[15:0] | 16'h2000) & 16'h3FFF);
      end
      idle();
      {ccr_wr_en_i, ccr_wr_data_i} = {1'b1, 5'h1A};
      m_sr[4:0] = 5'h1A;
      tick();
      chk_val(sr_o, m_sr);
      // ccr strobe still high here: the full status write must win
      sr_wr(16'h2705);
      idle();
      trace(1'b0, 1'b0);
      sr_wr(16'h6700);
      trace(1'b0, 1'b1);
      trace(1'b1, 1'b1);
      sr_wr(16'hA700);
      trace(1'b0, 1'b0);
      trace(1'b1, 1'b1);
      sr_wr(16'hE700);
      trace(1'b0, 1'b1);
      sr_wr(16'h2700);
      idle();
      for (int i = 0; i < 16; i++) begin
         gpr_wr(i[3:0], ccs_pkg::SZ_LONG, $urandom, 32'h0);
         rd_chk(i[3:0], 1'b1, i[1:0]);
      end
      for (int z = 0; z < 4; z++) begin
         gpr_wr(4'h2, ccs_pkg::ccs_size_t'(z), $urandom, $urandom);
         rd_chk(4'h2, 1'b0, 2'h3);
         rd_chk(4'h5, 1'b1, 2'h0);
         gpr_wr(4'h9, ccs_pkg::ccs_size_t'(z), $urandom | 32'h8000, $urandom);
         rd_chk(4'h9, 1'b0, 2'h1);
      end
      sr_wr(16'h3700);
      idle();
      // reading the stack pointer while it is written arms the master stack check
      gpr_rd_sel_i = 4'hF;
      gpr_wr(4'hF, ccs_pkg::SZ_LONG, $urandom, 32'h0);
      rd_chk(4'hF, 1'b1, 2'h2);
      sr_wr(16'h2700);
      rd_chk(4'hF, 1'b1, 2'h0);
      idle();
      r = $urandom;
      {pc_wr_en_i, pc_wr_data_i} = {1'b1, r};
      tick();
      chk_val(pc_o, r);
      repeat (4) begin
         r = $urandom;
         {vbr_wr_en_i, vbr_wr_data_i, vector_num_i} = {1'b1, r, r[7:0]};
         repeat (2) tick();
         chk_val(vector_addr_o, r + {r[7:0], 2'b00});
      end
      idle();
      {sfc_wr_en_i, space_wr_data_i} = {1'b1, 3'h1};
      tick();
      {sfc_wr_en_i, dfc_wr_en_i, space_wr_data_i} = {2'b01, 3'h2};
      {m_sfc, m_dfc} = {3'h1, 3'h2};
      tick();
      chk_val({source_space_code_reg_o, dest_space_code_reg_o}, {m_sfc, m_dfc});
      bus(1'b0, 1'b0, 1'b0);
      bus(1'b1, 1'b0, 1'b0);
      bus(1'b0, 1'b1, 1'b0);
      bus(1'b1, 1'b0, 1'b1);
      bus(1'b0, 1'b1, 1'b1);
      // bus cycles must end here, or the partner counts extra accesses
      idle();
      {icache_control_reg_wr_en_i, icache_control_reg_wr_data_i} = {1'b1, 32'h9};
      tick();
      chk_val({icache_control_reg_o[3:0], icache_enable_o, icache_clr_all_o}, 6'h07);
      icache_control_reg_wr_data_i = 32'h6;
      tick();
      chk_val({icache_control_reg_o[29:0], icache_freeze_o, icache_clr_entry_o}, 32'h0B);
      {icache_addr_reg_wr_en_i, icache_addr_reg_wr_data_i} = {1'b1, r};
      tick();
      chk_val(icache_addr_reg_o, r);
      idle();
      // user state last: nothing short of reset brings supervisor back
      sr_wr(16'h0700);
      idle();
      {vbr_wr_en_i, vbr_wr_data_i} = {1'b1, ~r};
      tick();
      chk_flag(priv_err_o, 1'b1);
      idle();
      chk_val(vbr_o, r);
      bus(1'b1, 1'b0, 1'b0);
      bus(1'b0, 1'b0, 1'b0);
      bus(1'b0, 1'b1, 1'b0);
      idle();
      gpr_wr(4'hF, ccs_pkg::SZ_LONG, $urandom, 32'h0);
      rd_chk(4'hF, 1'b1, 2'h0);
      sr_wr(16'hFFFF);
      idle();
      chk_val(m_count, n_bus);
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fails++;
      give_verdict();
   end
endmodule
`default_nettype wire
